// File: hw/clock_group_control.v
`timescale 1ns/1ps
`include "clock_group_map.vh"

// Notes on behaviour
// - Pin low: memory clock from bridge clock
// - Pin high: memory clock from external input
// - Peripheral groups derive from core clock
// - Registers at documented I/O addresses
// - Reserved bits read zero, ignore writes
// - Stable flag after 41032 reference cycles
// - Lock flag shows PLL phase lock
// - Reset bit holds PLL reset, resets 1
// - Oscillator off after idle when internal
// - Oscillator off at once when external
// - Power-down bit stops PLL, resets 0
// - Mode bit clear bypasses PLL and divider
// - Multiplier codes 2..15, others reserved
// - Prescaler divides by field plus one
module clock_group_control #(
  parameter STABLE_COUNT = `STABLE_CYCLES,
  parameter LOCK_COUNT   = `LOCK_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // I/O space register port
  input  wire [15:0] io_addr,
  input  wire        io_write,
  input  wire        io_read,
  input  wire [15:0] io_wdata,
  output reg  [15:0] io_rdata,
  // Clock sources as enables
  input  wire        ref_pulse,
  input  wire        pll_out_pulse,
  input  wire        external_memory_clock_input,
  // Pins and status inputs
  input  wire        external_memory_interface_clock_source_pin,
  input  wire        clock_generator_idle_status,
  input  wire        osc_counter_disable,
  input  wire        test_mode,
  // Analog controls
  output reg         pll_reset_out,
  output reg         pll_powerdown_out,
  output reg         oscillator_powerdown_out,
  output reg  [4:0]  pll_mult_factor,
  output reg  [4:0]  pll_prediv_ratio,
  // Clock group enables
  output wire        core_clock,
  output wire        fast_peripheral_clock,
  output wire        slow_peripheral_clock,
  output wire        ext_memory_clock,
  output wire        external_memory_interface_clock
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg        pll_mode_enable;       // Bypass when 0
  reg        pll_reset_bit;         // PLL held in reset when 1
  reg        oscillator_powerdown;  // Oscillator power-down request
  reg        pll_powerdown;         // PLL power-down
  reg [3:0]  core_source;           // Core clock source select
  reg [4:0]  pll_multiplier;        // Multiplier field
  reg        prescaler_enable;      // Prescaler enable
  reg [4:0]  pll_prescaler;         // Prescaler field
  reg [1:0]  fast_group_divider;    // Fast group ratio
  reg [1:0]  slow_group_divider;    // Slow group ratio
  reg [1:0]  ext_memory_group_divider; // Memory group ratio
  reg [15:0] osc_div_word;          // Oscillator output divider
  reg [15:0] wakeup_word;           // Wakeup enables
  reg [15:0] clkout_word;           // Clock output select
  reg        clock_input_source_mode; // 1: external clock input
  reg [16:0] stable_count;          // Oscillator stabilisation counter
  reg [15:0] lock_count;            // Relock counter
  reg        mode_active;           // Mode applied at pulse boundary
  reg        osc_was_down;          // Restart stabilisation on wake

  wire stable_flag;
  wire lock_flag;
  wire core_pulse;
  wire fast_src;

  // Valid multiplier code check
  function mult_valid;
    input [4:0] code;
    begin
      mult_valid = (code >= `MULT_MIN) && (code <= `MULT_MAX);
    end
  endfunction

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      pll_mode_enable          <= 1'b0;
      pll_reset_bit            <= 1'b1;
      oscillator_powerdown     <= 1'b0;
      pll_powerdown            <= 1'b0;
      core_source              <= `RST_CORE_CLOCK_SOURCE;
      pll_multiplier           <= `RST_FIELD5;
      prescaler_enable         <= `RST_PRESCALER_ENABLE;
      pll_prescaler            <= `RST_FIELD5;
      fast_group_divider       <= `RST_GROUP_DIVIDER;
      slow_group_divider       <= `RST_GROUP_DIVIDER;
      ext_memory_group_divider <= `RST_GROUP_DIVIDER;
      osc_div_word             <= `RST_WORD;
      wakeup_word              <= `RST_WORD;
      clkout_word              <= `RST_WORD;
      clock_input_source_mode  <= 1'b0;
    end else if (io_write) begin
      case (io_addr)
        `OFS_PLL_CONTROL_STATUS: begin
          // Only writable bits stored; others dropped
          pll_mode_enable      <= io_wdata[`BIT_PLL_MODE_ENABLE];
          pll_powerdown        <= io_wdata[`BIT_PLL_POWERDOWN];
          oscillator_powerdown <= io_wdata[`BIT_OSC_POWERDOWN];
          pll_reset_bit        <= io_wdata[`BIT_PLL_RESET];
        end
        `OFS_CORE_CLOCK_SOURCE: begin
          core_source <= io_wdata[3:0];
        end
        `OFS_PLL_MULTIPLIER: begin
          pll_multiplier <= io_wdata[`FIELD5_MSB:0];
        end
        `OFS_PLL_PRESCALER: begin
          prescaler_enable <= io_wdata[`BIT_PRESCALER_ENABLE];
          pll_prescaler    <= io_wdata[`FIELD5_MSB:0];
        end
        `OFS_FAST_GROUP_DIVIDER: begin
          fast_group_divider <= io_wdata[1:0];
        end
        `OFS_SLOW_GROUP_DIVIDER: begin
          slow_group_divider <= io_wdata[1:0];
        end
        `OFS_EXT_MEM_DIVIDER: begin
          ext_memory_group_divider <= io_wdata[1:0];
        end
        `OFS_OSC_OUTPUT_DIVIDER: begin
          osc_div_word <= io_wdata;
        end
        `OFS_WAKEUP_ENABLE: begin
          wakeup_word <= io_wdata;
        end
        `OFS_CLOCK_OUTPUT_SELECT: begin
          clkout_word <= io_wdata;
        end
        `OFS_CLOCK_MODE: begin
          clock_input_source_mode <= io_wdata[`BIT_CLOCK_INPUT_MODE];
        end
        default: begin
          // Unmapped address: write ignored
        end
      endcase
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      io_rdata <= `RST_WORD;
    end else if (io_read) begin
      case (io_addr)
        `OFS_PLL_CONTROL_STATUS: begin
          io_rdata <= {9'h000, stable_flag, lock_flag, 1'b0, pll_reset_bit,
                       oscillator_powerdown, pll_powerdown, pll_mode_enable};
        end
        `OFS_CORE_CLOCK_SOURCE:   io_rdata <= {12'h000, core_source};
        `OFS_PLL_MULTIPLIER:      io_rdata <= {11'h000, pll_multiplier};
        `OFS_PLL_PRESCALER:       io_rdata <= {prescaler_enable, 10'h000, pll_prescaler};
        `OFS_FAST_GROUP_DIVIDER:  io_rdata <= {14'h0000, fast_group_divider};
        `OFS_SLOW_GROUP_DIVIDER:  io_rdata <= {14'h0000, slow_group_divider};
        `OFS_EXT_MEM_DIVIDER:     io_rdata <= {14'h0000, ext_memory_group_divider};
        `OFS_OSC_OUTPUT_DIVIDER:  io_rdata <= osc_div_word;
        `OFS_WAKEUP_ENABLE:       io_rdata <= wakeup_word;
        `OFS_CLOCK_OUTPUT_SELECT: io_rdata <= clkout_word;
        `OFS_CLOCK_MODE:          io_rdata <= {15'h0000, clock_input_source_mode};
        default:                  io_rdata <= `RST_WORD;
      endcase
    end
  end

  // ****************************************************************
  // Oscillator stabilisation and power-down
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      stable_count             <= 17'h00000;
      oscillator_powerdown_out <= 1'b0;
      osc_was_down             <= 1'b0;
    end else begin
      // Internal source waits for idle, external source acts at once
      if (oscillator_powerdown && clock_input_source_mode) begin
        oscillator_powerdown_out <= 1'b1;
      end else if (oscillator_powerdown && clock_generator_idle_status) begin
        oscillator_powerdown_out <= 1'b1;
      end else if (!oscillator_powerdown) begin
        oscillator_powerdown_out <= 1'b0;
      end
      osc_was_down <= oscillator_powerdown_out;
      // Restart count on wake from power-down
      if (oscillator_powerdown_out || osc_was_down) begin
        stable_count <= 17'h00000;
      end else if (ref_pulse && (stable_count < STABLE_COUNT[16:0])) begin
        stable_count <= stable_count + 17'h00001;
      end
    end
  end

  assign stable_flag = (stable_count >= STABLE_COUNT[16:0]) || osc_counter_disable || test_mode;

  // ****************************************************************
  // PLL control and lock model
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      pll_reset_out     <= 1'b1;
      pll_powerdown_out <= 1'b0;
      pll_mult_factor   <= `RST_FIELD5;
      pll_prediv_ratio  <= `RST_FIELD5;
      lock_count        <= 16'h0000;
    end else begin
      pll_reset_out     <= pll_reset_bit;
      pll_powerdown_out <= pll_powerdown;
      // Reserved multiplier codes leave the last valid factor
      if (mult_valid(pll_multiplier)) begin
        pll_mult_factor <= pll_multiplier;
      end
      pll_prediv_ratio <= prescaler_enable ? pll_prescaler : `RST_FIELD5;
      if (pll_reset_bit || pll_powerdown) begin
        lock_count <= 16'h0000;
      end else if (ref_pulse && (lock_count < LOCK_COUNT[15:0])) begin
        lock_count <= lock_count + 16'h0001;
      end
    end
  end

  assign lock_flag = (lock_count >= LOCK_COUNT[15:0]);

  // ****************************************************************
  // Bypass switch at source pulse boundary
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      mode_active <= 1'b0;
    end else if (!core_pulse) begin
      mode_active <= pll_mode_enable;
    end
  end

  assign core_pulse = mode_active ? pll_out_pulse : ref_pulse;
  assign core_clock = core_pulse;

  // Mode mux sits ahead of every group divider
  assign fast_src = core_pulse;

  // ****************************************************************
  // Group dividers
  // ****************************************************************
  group_divider #(.WIDTH(2)) fast_div (
    .clk       (clk),
    .rst       (rst),
    .in_pulse  (fast_src),
    .ratio     (fast_group_divider),
    .out_pulse (fast_peripheral_clock)
  );

  group_divider #(.WIDTH(2)) slow_div (
    .clk       (clk),
    .rst       (rst),
    .in_pulse  (core_pulse),
    .ratio     (slow_group_divider),
    .out_pulse (slow_peripheral_clock)
  );

  group_divider #(.WIDTH(2)) mem_div (
    .clk       (clk),
    .rst       (rst),
    .in_pulse  (core_pulse),
    .ratio     (ext_memory_group_divider),
    .out_pulse (ext_memory_clock)
  );

  // Memory interface clock source select
  assign external_memory_interface_clock = external_memory_interface_clock_source_pin ?
                                           external_memory_clock_input :
                                           ext_memory_clock;

endmodule

// File: hw/clock_group_map.vh
`ifndef CLOCK_GROUP_MAP_VH
`define CLOCK_GROUP_MAP_VH

// ****************************************************************
// Register offsets (word addresses in the I/O space)
// ****************************************************************
`define OFS_PLL_CONTROL_STATUS   16'h1C80
`define OFS_CORE_CLOCK_SOURCE    16'h1C82
`define OFS_PLL_MULTIPLIER       16'h1C88
`define OFS_PLL_PRESCALER        16'h1C8A
`define OFS_FAST_GROUP_DIVIDER   16'h1C8C
`define OFS_SLOW_GROUP_DIVIDER   16'h1C8E
`define OFS_EXT_MEM_DIVIDER      16'h1C90
`define OFS_OSC_OUTPUT_DIVIDER   16'h1C92
`define OFS_WAKEUP_ENABLE        16'h1C98
`define OFS_CLOCK_OUTPUT_SELECT  16'h8400
`define OFS_CLOCK_MODE           16'h8C00

// ****************************************************************
// Control/status bit positions
// ****************************************************************
`define BIT_PLL_MODE_ENABLE      0
`define BIT_PLL_POWERDOWN        1
`define BIT_OSC_POWERDOWN        2
`define BIT_PLL_RESET            3
`define BIT_LOCK                 5
`define BIT_STABLE               6
`define BIT_CLOCK_INPUT_MODE     0
`define BIT_PRESCALER_ENABLE     15

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CORE_CLOCK_SOURCE    4'hB
`define RST_GROUP_DIVIDER        2'h3
`define RST_PRESCALER_ENABLE     1'h1
`define RST_FIELD5               5'h00
`define RST_WORD                 16'h0000

// ****************************************************************
// Field widths and limits
// ****************************************************************
`define FIELD5_MSB               4
`define MULT_MIN                 5'h02
`define MULT_MAX                 5'h0F
`define STABLE_CYCLES            41032
`define LOCK_CYCLES              256

`endif

// File: hw/group_divider.v
`timescale 1ns/1ps

// ****************************************************************
// Clock group divider: produces a one-cycle enable every ratio plus one input pulses
// ****************************************************************
module group_divider #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Source enable and ratio (divide by ratio + 1)
  input  wire             in_pulse,
  input  wire [WIDTH-1:0] ratio,
  // Divided enable
  output reg              out_pulse
);

  reg [WIDTH-1:0] count;   // Input pulses since last output

  // Count only on whole source pulses so no output pulse is truncated
  always @(posedge clk) begin
    if (rst) begin
      count     <= {WIDTH{1'b0}};
      out_pulse <= 1'b0;
    end else if (in_pulse) begin
      if (count >= ratio) begin
        count     <= {WIDTH{1'b0}};
        out_pulse <= 1'b1;
      end else begin
        count     <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        out_pulse <= 1'b0;
      end
    end else begin
      out_pulse <= 1'b0;
    end
  end

endmodule

// File: verif/clock_group_control_monitor.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker for the clock group control block
// ****************************************************************
module clock_group_control_monitor #(
  parameter STABLE_COUNT = 8,
  parameter LOCK_COUNT   = 4
) (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Register port
  input wire [15:0] io_addr,
  input wire        io_write,
  input wire        io_read,
  input wire [15:0] io_wdata,
  input wire [15:0] io_rdata,
  // Pins and status
  input wire        external_memory_clock_input,
  input wire        external_memory_interface_clock_source_pin,
  input wire        clock_generator_idle_status,
  // Outputs under watch
  input wire        pll_reset_out,
  input wire        pll_powerdown_out,
  input wire        oscillator_powerdown_out,
  input wire [4:0]  pll_mult_factor,
  input wire [4:0]  pll_prediv_ratio,
  input wire        ext_memory_clock,
  input wire        external_memory_interface_clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg ext_mode; // Shadow of the clock input source mode bit
  // Track clock mode writes
  always @(posedge clk) begin
    if (rst) ext_mode <= 1'b0;
    else if (io_write && io_addr == 16'h8C00) ext_mode <= io_wdata[0];
  end
  // Write to the control/status word
  sequence s_csr_wr;
    io_write && io_addr == 16'h1C80;
  endsequence
  a_mem_clk_internal: assert property (!external_memory_interface_clock_source_pin |->
    external_memory_interface_clock == ext_memory_clock) else $error("memory clock not internal");
  a_mem_clk_external: assert property (external_memory_interface_clock_source_pin |->
    external_memory_interface_clock == external_memory_clock_input) else $error("memory clock not pin");
  a_reset_values: assert property (disable iff (1'b0) rst |=>
    pll_reset_out && !pll_powerdown_out && io_rdata == 16'h0000) else $error("bad reset values");
  a_csr_reserved_zero: assert property (io_read && io_addr == 16'h1C80 |=>
    io_rdata[15:7] == 9'h000 && io_rdata[4] == 1'b0) else $error("reserved bit set");
  a_csr_write_effect: assert property (s_csr_wr |=> ##1 pll_reset_out == $past(io_wdata[3], 2)
    && pll_powerdown_out == $past(io_wdata[1], 2)) else $error("control bits not applied");
  a_mult_code_select: assert property (io_write && io_addr == 16'h1C88 |=> ##1 pll_mult_factor ==
    (($past(io_wdata[4:0], 2) >= 5'h02 && $past(io_wdata[4:0], 2) <= 5'h0F) ? $past(io_wdata[4:0], 2)
    : $past(pll_mult_factor))) else $error("multiplier code wrong");
  a_prescaler_ratio: assert property (io_write && io_addr == 16'h1C8A |=> ##1 pll_prediv_ratio ==
    ($past(io_wdata[15], 2) ? $past(io_wdata[4:0], 2) : 5'h00)) else $error("prescaler ratio wrong");
  a_osc_wait_idle: assert property ($rose(oscillator_powerdown_out) |-> ext_mode
    || clock_generator_idle_status || $past(clock_generator_idle_status)) else $error("osc off early");
  a_osc_ext_now: assert property (ext_mode && io_write && io_addr == 16'h1C80 && io_wdata[2]
    |-> ##[1:2] oscillator_powerdown_out) else $error("osc not off at once");
endmodule

bind clock_group_control clock_group_control_monitor #(.STABLE_COUNT(STABLE_COUNT), .LOCK_COUNT(LOCK_COUNT)) mon (
  .clk(clk), .rst(rst), .io_addr(io_addr), .io_write(io_write), .io_read(io_read),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .external_memory_clock_input(external_memory_clock_input),
  .external_memory_interface_clock_source_pin(external_memory_interface_clock_source_pin), .clock_generator_idle_status(clock_generator_idle_status),
  .pll_reset_out(pll_reset_out), .pll_powerdown_out(pll_powerdown_out),
  .oscillator_powerdown_out(oscillator_powerdown_out), .pll_mult_factor(pll_mult_factor),
  .pll_prediv_ratio(pll_prediv_ratio), .ext_memory_clock(ext_memory_clock),
  .external_memory_interface_clock(external_memory_interface_clock));

// File: verif/pll_clock_group_control_tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench for the clock group control block
// ****************************************************************
module pll_clock_group_control_tb;
  reg         clk = 1'b0, rst = 1'b1, io_write = 1'b0, io_read = 1'b0;
  reg  [15:0] io_addr = 16'h0000, io_wdata = 16'h0000;
  reg         ref_pulse = 1'b0, pll_out_pulse = 1'b0, ext_in = 1'b0, pin = 1'b0;
  reg         idle = 1'b0, cnt_dis = 1'b0, tmode = 1'b0;
  wire [15:0] io_rdata;
  wire [4:0]  mult, pre;
  wire        prst, ppd, opd, cclk, fclk, sclk, eclk, mclk;
  integer     num_errors = 0, n_checks = 0, cc, cf, cs, ce, k;
  integer     seed = 32'h44C1;
  reg  [4:0]  m, p;

  clock_group_control #(.STABLE_COUNT(8), .LOCK_COUNT(4)) DUT (
    .clk(clk), .rst(rst), .io_addr(io_addr), .io_write(io_write), .io_read(io_read),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ref_pulse(ref_pulse), .pll_out_pulse(pll_out_pulse),
    .external_memory_clock_input(ext_in), .external_memory_interface_clock_source_pin(pin),
    .clock_generator_idle_status(idle), .osc_counter_disable(cnt_dis), .test_mode(tmode),
    .pll_reset_out(prst), .pll_powerdown_out(ppd), .oscillator_powerdown_out(opd),
    .pll_mult_factor(mult), .pll_prediv_ratio(pre), .core_clock(cclk), .fast_peripheral_clock(fclk),
    .slow_peripheral_clock(sclk), .ext_memory_clock(eclk), .external_memory_interface_clock(mclk));

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Count the group enables
  always @(posedge clk) begin
    cc = cc + cclk;
    cf = cf + fclk;
    cs = cs + sclk;
    ce = ce + eclk;
  end
  // Compare one value and count it
  task chk16(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One register write
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_write = 1'b1;
      @(negedge clk);
      io_write = 1'b0;
    end
  endtask
  // One register read with comparison
  task rd(input [15:0] a, input [15:0] exp);
    begin
      @(negedge clk);
      io_addr = a;
      io_read = 1'b1;
      @(negedge clk);
      io_read = 1'b0;
      chk16(io_rdata, exp);
    end
  endtask
  // Send n source pulses, one every other cycle, then let dividers drain
  task run(input rp, input pp, input integer n);
    integer i;
    begin
      @(negedge clk);
      cc = 0; cf = 0; cs = 0; ce = 0;
      for (i = 0; i < 2 * n; i = i + 1) begin
        ref_pulse = rp & ~i[0];
        pll_out_pulse = pp & ~i[0];
        @(negedge clk);
      end
      ref_pulse = 1'b0;
      pll_out_pulse = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
  // Verdict and end of run
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    #(50 * 20000);
    num_errors = num_errors + 1;
    print_verdict;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rd(16'h1C80, 16'h0008);
    rd(16'h1C82, 16'h000B);
    rd(16'h1C8A, 16'h8000);
    rd(16'h1C8C, 16'h0003);
    rd(16'h1C84, 16'h0000);
    run(1, 0, 40);
    chk16(cc, 40);
    chk16(cf, 10);
    chk16(cs + ce, 20);
    rd(16'h1C80, 16'h0048);
    wr(16'h1C80, 16'hFF9A);
    rd(16'h1C80, 16'h004A);
    chk16(ppd, 1'b1);
    for (k = 0; k < 3; k = k + 1) begin
      m = 5'h02 + ($unsigned($random(seed)) % 14);
      p = $random(seed);
      wr(16'h1C80, 16'h0000);
      wr(16'h1C80, 16'h0008);
      wr(16'h1C88, {11'h000, m});
      wr(16'h1C8A, {11'h400, p});
      // Analog settings follow the register one cycle later
      @(negedge clk);
      chk16(mult, m);
      chk16(pre, p);
      rd(16'h1C88, {11'h000, m});
      repeat (20) @(negedge clk);
      wr(16'h1C80, 16'h0000);
      @(negedge clk);
      chk16(prst, 1'b0);
      run(1, 0, 8);
      rd(16'h1C80, 16'h0060);
      wr(16'h1C80, 16'h0001);
    end
    run(0, 1, 40);
    chk16(cf, 10);
    run(1, 0, 40);
    chk16(cf, 0);
    wr(16'h1C8C, 16'h0001);
    run(0, 1, 40);
    chk16(cf, 20);
    chk16(cs, 10);
    wr(16'h1C88, 16'h0010);
    wr(16'h1C88, 16'h0001);
    chk16(mult, m);
    wr(16'h1C8A, 16'h0005);
    @(negedge clk);
    chk16(pre, 5'h00);
    wr(16'h1C80, 16'h0004);
    repeat (4) @(negedge clk);
    chk16(opd, 1'b0);
    idle = 1'b1;
    repeat (3) @(negedge clk);
    chk16(opd, 1'b1);
    idle = 1'b0;
    wr(16'h1C80, 16'h0000);
    wr(16'h8C00, 16'h0001);
    wr(16'h1C80, 16'h0004);
    @(negedge clk);
    chk16(opd, 1'b1);
    wr(16'h1C80, 16'h0008);
    rd(16'h1C80, 16'h0008);
    cnt_dis = 1'b1;
    rd(16'h1C80, 16'h0048);
    cnt_dis = 1'b0;
    tmode = 1'b1;
    rd(16'h1C80, 16'h0048);
    for (k = 0; k < 16; k = k + 1) begin
      @(negedge clk);
      pin = $random(seed);
      ext_in = $random(seed);
      #1;
      if (pin) begin
        chk16(mclk, ext_in);
      end else begin
        // Group dividers are idle here, so the internal clock is low
        chk16(mclk, 1'b0);
      end
    end
    print_verdict;
  end
endmodule
